// ==== hdl/fscp_core.sv ====
`timescale 1ns/10ps
// Summary of operation
// RQ1: Suspend sets paused flag; resume clears it
// RQ2: Security locks set once, cleared only by reset
// RQ3: Quad enable turns protect/hold pins into data
// RQ4: Enter four-wire mode ignored unless quad enabled
// RQ5: Four-wire mode keeps quad enable at one
// RQ6: Scheme select picks range or lock protection
// RQ7: All block locks set at reset
// RQ8: Drive field picks strength, default 25%
// RQ9: Pin select: hold at 0, reset at 1
// RQ10: Hold/reset only while quad enable is 0
// RQ11: Reserved bits read zero, writes ignored
// RQ12: Block-level range decode, top or bottom
// RQ13: Fine range decode 4KB to 32KB
// RQ14: Erase/program blocked if touching protected data
// RQ15: Complement bit inverts protected region
// RQ16: Locked units block writes; unlock clears lock
// RQ17: Protection decode purely combinational
module fscp_core
  import fscp_pkg::*;
(
  // System
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Serial link
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_n_o,
  // Erase/program target check
  input wire logic [fscp_pkg::ADDR_W-1:0] target_lo_i,
  input wire logic [fscp_pkg::ADDR_W-1:0] target_hi_i,
  output logic write_blocked_o,
  // Configuration outputs
  output logic paused_op_flag_o,
  output logic four_wire_command_mode_o,
  output logic [2:0] security_reg_read_only_o,
  output logic [1:0] drive_strength_o,
  output logic write_protect_fn_en_o,
  output logic hold_fn_en_o,
  output logic reset_fn_en_o,
  output logic io23_data_en_o
);
  import fscp_pkg::*;

  // ****************************************
  // State types
  // ****************************************
  typedef struct packed {
    logic [31:0] shift;
    logic [5:0] count;
    logic [7:0] out;
    logic reading;
  } fscp_link_t;

  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic fine_unit_select;
    logic top_bottom_select;
    logic [2:0] block_protect_level;
    logic complement_protect;
    logic [2:0] security_lock;
    logic quad_io_enable;
    logic paused_op_flag;
    logic four_wire_command_mode;
    logic protect_scheme_select;
    logic [1:0] drive_strength;
    logic pin_function_select;
    logic [NUM_LOCKS-1:0] block_locks;
  } fscp_state_t;

  fscp_link_t link_reg;
  fscp_link_t link_next;
  logic frame_reg;
  logic frame_rst_n;
  fscp_state_t state_reg;
  fscp_state_t state_next;
  logic [5:0] count_eff;
  logic [7:0] opcode_now;
  logic frame_end;
  logic [7:0] ex_op;
  logic [7:0] ex_data;
  logic [ADDR_W-1:0] ex_addr;
  logic range_hit;
  logic lock_hit;

  // ****************************************
  // Functions
  // ****************************************
  // Returns {empty, lo, hi} of the range chosen by the protect bits
  function automatic logic [2*ADDR_W:0] prot_range(input logic fine, input logic bottom,
                                                    input logic [2:0] level);
    logic [ADDR_W-1:0] size;
    logic [2:0] step;
    logic [ADDR_W-1:0] lo;
    logic [ADDR_W-1:0] hi;
    size = '0;
    step = '0;
    lo = '0;
    hi = ARRAY_TOP;
    if (level == BP_NONE) begin
      prot_range = {1'b1, lo, hi};
    end else if (level == BP_ALL) begin
      prot_range = {1'b0, lo, hi};
    end else begin
      if (fine) begin
        // Levels above 4 all stop at 32KB
        step = (level > BP_FINE_CAP) ? BP_FINE_CAP : level;
        size = SECTOR_SIZE << (step - 3'h1);
      end else begin
        size = BLOCK_SIZE << (level - 3'h1);
      end
      if (bottom) begin
        hi = size - 22'h000001;
      end else begin
        lo = ARRAY_TOP - size + 22'h000001;
      end
      prot_range = {1'b0, lo, hi};
    end
  endfunction

  // Base address of a lock unit
  function automatic logic [ADDR_W-1:0] unit_base(input int idx);
    if (idx < BOTTOM_SECTOR_BASE) begin
      unit_base = ADDR_W'(idx + 1) << BLOCK_SHIFT;
    end else if (idx < TOP_SECTOR_BASE) begin
      unit_base = ADDR_W'(idx - BOTTOM_SECTOR_BASE) << SECTOR_SHIFT;
    end else begin
      unit_base = TOP_BLOCK_BASE + (ADDR_W'(idx - TOP_SECTOR_BASE) << SECTOR_SHIFT);
    end
  endfunction

  // Lock unit that holds an address
  function automatic int unit_index(input logic [ADDR_W-1:0] addr);
    logic [5:0] blk;
    blk = addr[ADDR_W-1:BLOCK_SHIFT];
    if (blk == FIRST_BLOCK) begin
      unit_index = BOTTOM_SECTOR_BASE + int'(addr[BLOCK_SHIFT-1:SECTOR_SHIFT]);
    end else if (blk == LAST_BLOCK) begin
      unit_index = TOP_SECTOR_BASE + int'(addr[BLOCK_SHIFT-1:SECTOR_SHIFT]);
    end else begin
      unit_index = int'(blk) - 1;
    end
  endfunction

  // RQ11 reserved read zero
  function automatic logic [7:0] status_byte(input logic [7:0] op, input fscp_state_t s);
    logic [7:0] b;
    b = '0;
    case (op)
      OP_READ_SR1: begin
        b[SR1_SEC] = s.fine_unit_select;
        b[SR1_TB] = s.top_bottom_select;
        b[SR1_BP_HI:SR1_BP_LO] = s.block_protect_level;
      end
      OP_READ_SR2: begin
        b[SR2_PAUSED] = s.paused_op_flag;
        b[SR2_CMP] = s.complement_protect;
        b[SR2_LOCK_HI:SR2_LOCK_LO] = s.security_lock;
        b[SR2_QE] = s.quad_io_enable;
      end
      OP_READ_SR3: begin
        b[SR3_PIN_FN] = s.pin_function_select;
        b[SR3_DRV_HI:SR3_DRV_LO] = s.drive_strength;
        b[SR3_WPS] = s.protect_scheme_select;
      end
      default: begin
        b = '0;
      end
    endcase
    status_byte = b;
  endfunction

  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == OP_READ_SR1) || (op == OP_READ_SR2) || (op == OP_READ_SR3);
  endfunction

  // ****************************************
  // Link domain
  // ****************************************
  // Frame flag clears with chip select so the bit count restarts
  assign frame_rst_n = rst_n_i & ~cs_n_i;

  always_ff @(posedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      frame_reg <= 1'b0;
    end else begin
      frame_reg <= 1'b1;
    end
  end

  assign count_eff = frame_reg ? link_reg.count : 6'h00;
  assign opcode_now = {link_reg.shift[6:0], si_i};

  // Status bits change only between frames, so they are stable here
  always_comb begin
    link_next = link_reg;
    link_next.shift = {link_reg.shift[30:0], si_i};
    link_next.count = (count_eff == LEN_SATURATE) ? LEN_SATURATE : count_eff + 6'h01;
    if (count_eff + 6'h01 == LEN_OPCODE) begin
      link_next.out = status_byte(opcode_now, state_reg);
      link_next.reading = is_read(opcode_now);
    end else begin
      link_next.out = {link_reg.out[6:0], 1'b0};
      link_next.reading = link_reg.reading & (count_eff >= LEN_OPCODE);
    end
  end

  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  assign so_o = link_reg.out[7];
  assign so_oe_n_o = ~(frame_reg & link_reg.reading & (link_reg.count >= LEN_OPCODE));

  // ****************************************
  // Frame decode in system domain
  // ****************************************
  // Shift and count are frozen while chip select is high
  assign frame_end = state_reg.cs_sync & ~state_reg.cs_prev;
  assign ex_data = link_reg.shift[7:0];
  assign ex_addr = link_reg.shift[ADDR_W-1:0];

  always_comb begin
    case (link_reg.count)
      LEN_OPCODE: ex_op = link_reg.shift[7:0];
      LEN_ONE_DATA: ex_op = link_reg.shift[15:8];
      LEN_ADDRESS: ex_op = link_reg.shift[31:24];
      default: ex_op = '0;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    state_next.cs_meta = cs_n_i;
    state_next.cs_sync = state_reg.cs_meta;
    state_next.cs_prev = state_reg.cs_sync;
    if (frame_end && link_reg.count == LEN_OPCODE) begin
      case (ex_op)
        // RQ1 suspend sets flag
        OP_SUSPEND: state_next.paused_op_flag = 1'b1;
        // RQ1 resume clears flag
        OP_RESUME: state_next.paused_op_flag = 1'b0;
        // RQ4 needs quad enable
        OP_ENTER_FOUR_WIRE: state_next.four_wire_command_mode = state_reg.quad_io_enable;
        OP_EXIT_FOUR_WIRE: state_next.four_wire_command_mode = 1'b0;
        default: state_next.four_wire_command_mode = state_reg.four_wire_command_mode;
      endcase
    end else if (frame_end && link_reg.count == LEN_ONE_DATA) begin
      case (ex_op)
        OP_WRITE_SR1: begin
          state_next.fine_unit_select = ex_data[SR1_SEC];
          state_next.top_bottom_select = ex_data[SR1_TB];
          state_next.block_protect_level = ex_data[SR1_BP_HI:SR1_BP_LO];
        end
        OP_WRITE_SR2: begin
          state_next.complement_protect = ex_data[SR2_CMP];
          // RQ2 one-time lock bits
          state_next.security_lock = state_reg.security_lock | ex_data[SR2_LOCK_HI:SR2_LOCK_LO];
          // RQ5 held while four-wire
          state_next.quad_io_enable = ex_data[SR2_QE] | state_reg.four_wire_command_mode;
        end
        OP_WRITE_SR3: begin
          state_next.pin_function_select = ex_data[SR3_PIN_FN];
          state_next.drive_strength = ex_data[SR3_DRV_HI:SR3_DRV_LO];
          state_next.protect_scheme_select = ex_data[SR3_WPS];
        end
        default: state_next.quad_io_enable = state_reg.quad_io_enable;
      endcase
    end else if (frame_end && link_reg.count == LEN_ADDRESS && ex_op == OP_BLOCK_UNLOCK) begin
      // RQ16 unlock one unit
      state_next.block_locks[unit_index(ex_addr)] = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
      state_reg.cs_meta <= 1'b1;
      state_reg.cs_sync <= 1'b1;
      state_reg.cs_prev <= 1'b1;
      state_reg.security_lock <= SEC_LOCK_RESET;
      state_reg.drive_strength <= DRV_RESET;
      // RQ7 locks set at reset
      state_reg.block_locks <= LOCKS_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Protection check
  // ****************************************
  // RQ17 combinational decode
  always_comb begin
    logic [2*ADDR_W:0] r;
    logic [ADDR_W-1:0] lo;
    logic [ADDR_W-1:0] hi;
    r = prot_range(state_reg.fine_unit_select, state_reg.top_bottom_select,
                   state_reg.block_protect_level);
    lo = r[2*ADDR_W-1:ADDR_W];
    hi = r[ADDR_W-1:0];
    if (state_reg.complement_protect) begin
      // RQ15 inverted region
      range_hit = r[2*ADDR_W] | ~((target_lo_i >= lo) & (target_hi_i <= hi));
    end else begin
      // RQ12 RQ13 overlap test
      range_hit = ~r[2*ADDR_W] & (target_lo_i <= hi) & (target_hi_i >= lo);
    end
  end

  always_comb begin
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] last;
    lock_hit = 1'b0;
    base = '0;
    last = '0;
    for (int i = 0; i < NUM_LOCKS; i++) begin
      base = unit_base(i);
      last = base + ((i < MID_BLOCKS) ? BLOCK_SIZE : SECTOR_SIZE) - 22'h000001;
      // RQ16 locked unit touched
      lock_hit = lock_hit | (state_reg.block_locks[i] & (target_lo_i <= last) & (target_hi_i >= base));
    end
  end

  // RQ6 RQ14 scheme select
  assign write_blocked_o = state_reg.protect_scheme_select ? lock_hit : range_hit;

  // ****************************************
  // Configuration outputs
  // ****************************************
  assign paused_op_flag_o = state_reg.paused_op_flag;
  assign four_wire_command_mode_o = state_reg.four_wire_command_mode;
  // RQ2 security registers read-only
  assign security_reg_read_only_o = state_reg.security_lock;
  // RQ8 drive strength
  assign drive_strength_o = state_reg.drive_strength;
  // RQ3 RQ10 pin functions
  assign write_protect_fn_en_o = ~state_reg.quad_io_enable;
  // RQ9 hold or reset
  assign hold_fn_en_o = ~state_reg.quad_io_enable & ~state_reg.pin_function_select;
  assign reset_fn_en_o = ~state_reg.quad_io_enable & state_reg.pin_function_select;
  assign io23_data_en_o = state_reg.quad_io_enable;

endmodule // fscp_core

// ==== hdl/fscp_pkg.sv ====
package fscp_pkg;

  // ****************************************
  // Array geometry
  // ****************************************
  localparam int ADDR_W = 22;
  localparam logic [21:0] ARRAY_TOP = 22'h3FFFFF;
  localparam logic [21:0] BLOCK_SIZE = 22'h010000;
  localparam logic [21:0] SECTOR_SIZE = 22'h001000;
  localparam logic [21:0] TOP_BLOCK_BASE = 22'h3F0000;
  localparam int BLOCK_SHIFT = 16;
  localparam int SECTOR_SHIFT = 12;
  localparam logic [5:0] FIRST_BLOCK = 6'h00;
  localparam logic [5:0] LAST_BLOCK = 6'h3F;
  localparam int NUM_LOCKS = 94;
  localparam int MID_BLOCKS = 62;
  localparam int SECTORS_PER_END = 16;
  localparam int BOTTOM_SECTOR_BASE = MID_BLOCKS;
  localparam int TOP_SECTOR_BASE = MID_BLOCKS + SECTORS_PER_END;

  // ****************************************
  // Block-protect levels
  // ****************************************
  localparam logic [2:0] BP_NONE = 3'h0;
  localparam logic [2:0] BP_ALL = 3'h7;
  localparam logic [2:0] BP_FINE_CAP = 3'h4;

  // ****************************************
  // Instruction codes
  // ****************************************
  localparam logic [7:0] OP_WRITE_SR1 = 8'h01;
  localparam logic [7:0] OP_WRITE_SR2 = 8'h31;
  localparam logic [7:0] OP_WRITE_SR3 = 8'h11;
  localparam logic [7:0] OP_READ_SR1 = 8'h05;
  localparam logic [7:0] OP_READ_SR2 = 8'h35;
  localparam logic [7:0] OP_READ_SR3 = 8'h15;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_ENTER_FOUR_WIRE = 8'h38;
  localparam logic [7:0] OP_EXIT_FOUR_WIRE = 8'hFF;
  localparam logic [7:0] OP_BLOCK_UNLOCK = 8'h39;

  // ****************************************
  // Frame lengths in link bits
  // ****************************************
  localparam logic [5:0] LEN_OPCODE = 6'h08;
  localparam logic [5:0] LEN_ONE_DATA = 6'h10;
  localparam logic [5:0] LEN_ADDRESS = 6'h20;
  localparam logic [5:0] LEN_SATURATE = 6'h3F;

  // ****************************************
  // Status field positions
  // ****************************************
  localparam int SR1_SEC = 6;
  localparam int SR1_TB = 5;
  localparam int SR1_BP_HI = 4;
  localparam int SR1_BP_LO = 2;
  localparam int SR2_PAUSED = 7;
  localparam int SR2_CMP = 6;
  localparam int SR2_LOCK_HI = 5;
  localparam int SR2_LOCK_LO = 3;
  localparam int SR2_QE = 1;
  localparam int SR3_PIN_FN = 7;
  localparam int SR3_DRV_HI = 6;
  localparam int SR3_DRV_LO = 5;
  localparam int SR3_WPS = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [1:0] DRV_RESET = 2'h3;
  localparam logic [2:0] SEC_LOCK_RESET = 3'h0;
  localparam logic [NUM_LOCKS-1:0] LOCKS_RESET = {NUM_LOCKS{1'b1}};

endpackage

// ==== verification/fscp_core_asserts.sv ====
`timescale 1ns/10ps
module fscp_core_asserts (
  // System
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Link
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic so_o,
  input wire logic so_oe_n_o,
  // Check port
  input wire logic [fscp_pkg::ADDR_W-1:0] target_lo_i,
  input wire logic [fscp_pkg::ADDR_W-1:0] target_hi_i,
  input wire logic write_blocked_o,
  // Config
  input wire logic paused_op_flag_o,
  input wire logic four_wire_command_mode_o,
  input wire logic [2:0] security_reg_read_only_o,
  input wire logic [1:0] drive_strength_o,
  input wire logic write_protect_fn_en_o,
  input wire logic hold_fn_en_o,
  input wire logic reset_fn_en_o,
  input wire logic io23_data_en_o
);
  import fscp_pkg::*;
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_WP_FN: assert property (write_protect_fn_en_o == !io23_data_en_o)
    else $error("write protect function does not follow quad enable");
  AST_PIN_DATA: assert property (io23_data_en_o |-> !(hold_fn_en_o || reset_fn_en_o))
    else $error("hold or reset active with quad enable");
  AST_PIN_SEL: assert property (!io23_data_en_o |-> (hold_fn_en_o ^ reset_fn_en_o))
    else $error("shared pin function not exactly one");
  AST_LOCK_KEEP: assert property (($past(security_reg_read_only_o) & ~security_reg_read_only_o) == 3'h0)
    else $error("security lock cleared");
  AST_QE_HELD: assert property (four_wire_command_mode_o |-> io23_data_en_o)
    else $error("quad enable low in four-wire mode");
  AST_ENTER_QE: assert property ($rose(four_wire_command_mode_o) |-> $past(io23_data_en_o))
    else $error("four-wire mode entered without quad enable");
  AST_DRV_DEF: assert property ($rose(rst_n_i) |-> drive_strength_o == DRV_RESET && !paused_op_flag_o)
    else $error("drive or pause wrong after reset");
  AST_PAUSE_FRAME: assert property ($changed(paused_op_flag_o) |-> cs_n_i && $past(cs_n_i, 2))
    else $error("pause flag moved inside a frame");
  AST_DRV_FRAME: assert property ($changed(drive_strength_o) |-> cs_n_i && $past(cs_n_i, 2))
    else $error("drive strength moved inside a frame");
  COV_FOUR: cover property ($rose(four_wire_command_mode_o));
  COV_PAUSE: cover property ($rose(paused_op_flag_o));
  COV_UNBLOCK: cover property ($fell(write_blocked_o));
endmodule // fscp_core_asserts

bind fscp_core fscp_core_asserts i_fscp_core_asserts (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .si_i(si_i), .so_o(so_o),
  .so_oe_n_o(so_oe_n_o), .target_lo_i(target_lo_i), .target_hi_i(target_hi_i),
  .write_blocked_o(write_blocked_o), .paused_op_flag_o(paused_op_flag_o),
  .four_wire_command_mode_o(four_wire_command_mode_o), .security_reg_read_only_o(security_reg_read_only_o),
  .drive_strength_o(drive_strength_o), .write_protect_fn_en_o(write_protect_fn_en_o),
  .hold_fn_en_o(hold_fn_en_o), .reset_fn_en_o(reset_fn_en_o), .io23_data_en_o(io23_data_en_o));

// ==== verification/fscp_host_model.sv ====
`timescale 1ns/10ps
module fscp_host_model (
  // Link
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_n_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // Clock stands still between frames; odd offset keeps phase apart
  task automatic frame(input int n, input logic [31:0] w, output logic [7:0] rd);
    rd = 8'h00;
    #7 cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      si_o = w[31-i];
      #32 sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
      if (i >= 7 && i < 15) begin
        rd[14-i] = so_oe_n_i ? 1'bx : so_i;
      end
    end
    #32 cs_n_o = 1'b1;
    // Released line must not look like held data
    si_o = ~si_o;
    #600;
  endtask
endmodule // fscp_host_model

// ==== verification/tb_fscp_core.sv ====
`timescale 1ns/10ps
module tb_fscp_core;
  import fscp_pkg::*;
  logic clk_i, rst_n_i, sclk_i, cs_n_i, si_i, so_o, so_oe_n_o, write_blocked_o, paused_op_flag_o;
  logic four_wire_command_mode_o, write_protect_fn_en_o, hold_fn_en_o, reset_fn_en_o, io23_data_en_o;
  logic [ADDR_W-1:0] target_lo_i, target_hi_i, lo, hi, sz;
  logic [2:0] security_reg_read_only_o;
  logic [1:0] drive_strength_o;
  logic [7:0] rd;
  int errors, checked;

  fscp_core i_fscp_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .si_i(si_i),
    .so_o(so_o), .so_oe_n_o(so_oe_n_o), .target_lo_i(target_lo_i), .target_hi_i(target_hi_i),
    .write_blocked_o(write_blocked_o), .paused_op_flag_o(paused_op_flag_o),
    .four_wire_command_mode_o(four_wire_command_mode_o), .security_reg_read_only_o(security_reg_read_only_o),
    .drive_strength_o(drive_strength_o), .write_protect_fn_en_o(write_protect_fn_en_o),
    .hold_fn_en_o(hold_fn_en_o), .reset_fn_en_o(reset_fn_en_o), .io23_data_en_o(io23_data_en_o));
  fscp_host_model i_fscp_host_model (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .si_o(si_i), .so_i(so_o),
    .so_oe_n_i(so_oe_n_o));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // ****************************************
  // Access tasks
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cmd(input logic [7:0] op);
    i_fscp_host_model.frame(8, {op, 24'h000000}, rd);
  endtask
  task wr(input logic [7:0] op, input logic [7:0] d);
    i_fscp_host_model.frame(16, {op, d, 16'h0000}, rd);
  endtask
  task rchk(input logic [7:0] op, input logic [7:0] e);
    i_fscp_host_model.frame(16, {op, 24'h000000}, rd);
    chk({24'h000000, rd}, {24'h000000, e});
  endtask
  // Decode is combinational, so look in the same cycle
  task blk(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b, input logic e);
    @(posedge clk_i);
    target_lo_i <= a;
    target_hi_i <= b;
    @(negedge clk_i);
    chk({31'h0, write_blocked_o}, {31'h0, e});
  endtask
  task cfg(input logic [10:0] e);
    chk({21'h0, drive_strength_o, hold_fn_en_o, reset_fn_en_o, write_protect_fn_en_o, io23_data_en_o,
      paused_op_flag_o, four_wire_command_mode_o, security_reg_read_only_o}, {21'h0, e});
  endtask
  task pins(input logic [4:0] e);
    chk({27'h0, four_wire_command_mode_o, write_protect_fn_en_o, hold_fn_en_o, reset_fn_en_o, io23_data_en_o},
      {27'h0, e});
  endtask
  task rst;
    rst_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask
  task done(input string s);
    $display("Test %s finished", s);
  endtask
  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    #1000000;
    errors++;
    tally_and_finish;
  end
  initial begin
    errors = 0;
    checked = 0;
    rst_n_i = 1'b0;
    target_lo_i = '0;
    target_hi_i = '0;
    rst;
    cfg(11'h740);
    rchk(OP_READ_SR3, 8'h60);
    rchk(OP_READ_SR2, 8'h00);
    blk(22'h000000, ARRAY_TOP, 1'b0);
    cmd(OP_SUSPEND);
    rchk(OP_READ_SR2, 8'h80);
    cmd(OP_RESUME);
    rchk(OP_READ_SR2, 8'h00);
    done("defaults and suspend");
    for (int p = 0; p < 2; p++) begin
      for (int d = 0; d < 4; d++) begin
        wr(OP_WRITE_SR3, {p[0], d[1:0], 5'h00});
        chk({30'h0, drive_strength_o}, d);
        chk({30'h0, hold_fn_en_o, reset_fn_en_o}, {30'h0, ~p[0], p[0]});
        rchk(OP_READ_SR3, {p[0], d[1:0], 5'h00});
      end
    end
    done("drive and pin");
    wr(OP_WRITE_SR2, 8'h10);
    chk({29'h0, security_reg_read_only_o}, 32'h2);
    wr(OP_WRITE_SR2, 8'h28);
    wr(OP_WRITE_SR2, 8'h00);
    rchk(OP_READ_SR2, 8'h38);
    done("security locks");
    cmd(OP_ENTER_FOUR_WIRE);
    pins(5'h0A);
    wr(OP_WRITE_SR2, 8'h02);
    cmd(OP_ENTER_FOUR_WIRE);
    pins(5'h11);
    wr(OP_WRITE_SR2, 8'h00);
    pins(5'h11);
    cmd(OP_EXIT_FOUR_WIRE);
    wr(OP_WRITE_SR2, 8'h00);
    pins(5'h0A);
    done("quad enable");
    for (int s = 0; s < 2; s++) begin
      for (int t = 0; t < 2; t++) begin
        for (int l = 1; l < 7; l++) begin
          sz = s ? (l > 3 ? 22'h008000 : SECTOR_SIZE << (l - 1)) : BLOCK_SIZE << (l - 1);
          lo = t ? 22'h000000 : ARRAY_TOP - sz + 22'h000001;
          hi = lo + sz - 22'h000001;
          wr(OP_WRITE_SR1, {1'b0, s[0], t[0], l[2:0], 2'h0});
          rchk(OP_READ_SR1, {1'b0, s[0], t[0], l[2:0], 2'h0});
          blk(lo, hi, 1'b1);
          blk(t ? hi + 22'h000001 : 22'h000000, t ? ARRAY_TOP : lo - 22'h000001, 1'b0);
          blk(t ? hi : lo - 22'h000001, t ? hi + 22'h000001 : lo, 1'b1);
        end
      end
    end
    wr(OP_WRITE_SR1, 8'h1C);
    blk(22'h200000, 22'h200000, 1'b1);
    wr(OP_WRITE_SR1, 8'h04);
    wr(OP_WRITE_SR2, 8'h40);
    blk(22'h3F0000, ARRAY_TOP, 1'b0);
    blk(22'h3EFFFF, 22'h3EFFFF, 1'b1);
    wr(OP_WRITE_SR2, 8'h00);
    done("range decode");
    wr(OP_WRITE_SR1, 8'h1C);
    wr(OP_WRITE_SR3, 8'h04);
    blk(22'h100000, 22'h100000, 1'b1);
    i_fscp_host_model.frame(32, {OP_BLOCK_UNLOCK, 24'h100000}, rd);
    blk(22'h100000, 22'h10FFFF, 1'b0);
    blk(22'h10FFFF, 22'h110000, 1'b1);
    i_fscp_host_model.frame(32, {OP_BLOCK_UNLOCK, 24'h001000}, rd);
    blk(22'h001000, 22'h001FFF, 1'b0);
    blk(22'h000FFF, 22'h001000, 1'b1);
    wr(OP_WRITE_SR3, 8'h00);
    blk(22'h100000, 22'h100000, 1'b1);
    done("block locks");
    cmd(OP_SUSPEND);
    @(posedge clk_i);
    rst;
    cfg(11'h740);
    wr(OP_WRITE_SR3, 8'h04);
    blk(22'h100000, 22'h100000, 1'b1);
    done("second reset");
    tally_and_finish;
  end
endmodule // tb_fscp_core
